// [inc/lfc_pkg.sv]
// constants, index layout and types of the loop filter coefficient block
// assumes one clock domain; shared by every core file and the bench
//
// Summary of operation
// R1: each channel and mode holds an 8-bit low-frequency gain code, 0.3 dB/step, 20 dB.
// R2: a separate 8-bit high-frequency gain code, same 0.3 dB/step scaling.
// R3: an 8-bit zero placement setting per channel and per mode.
// R4: an 8-bit pole placement setting per channel and per mode.
// R5: light load set is independent and is applied while in light load mode.
// R6: channel B has its own full set and filters independently of A.
// R7: light load pole of B and light load high gains are held too.
// R8: all coefficient registers read/write, status read only; new values apply only at a filter update boundary.
`default_nettype none

package lfc_pkg;

	localparam int LFC_ADDR_W   = 16;
	localparam int LFC_DATA_W   = 8;
	localparam int LFC_NUM_REGS = 16;
	localparam int LFC_IDX_W    = 4;

	// register offsets, one byte each
	localparam logic [15:0] LFC_BASE_ADDR     = 16'hFE2C;
	localparam logic [15:0] LFC_A_NORM_LFGAIN = 16'hFE2C;
	localparam logic [15:0] LFC_B_NORM_LFGAIN = 16'hFE2D;
	localparam logic [15:0] LFC_A_NORM_ZERO   = 16'hFE2E;
	localparam logic [15:0] LFC_B_NORM_ZERO   = 16'hFE2F;
	localparam logic [15:0] LFC_A_NORM_POLE   = 16'hFE30;
	localparam logic [15:0] LFC_B_NORM_POLE   = 16'hFE31;
	localparam logic [15:0] LFC_A_NORM_HFGAIN = 16'hFE32;
	localparam logic [15:0] LFC_B_NORM_HFGAIN = 16'hFE33;
	localparam logic [15:0] LFC_A_LITE_LFGAIN = 16'hFE34;
	localparam logic [15:0] LFC_B_LITE_LFGAIN = 16'hFE35;
	localparam logic [15:0] LFC_A_LITE_ZERO   = 16'hFE36;
	localparam logic [15:0] LFC_B_LITE_ZERO   = 16'hFE37;
	localparam logic [15:0] LFC_A_LITE_POLE   = 16'hFE38;
	localparam logic [15:0] LFC_B_LITE_POLE   = 16'hFE39;
	localparam logic [15:0] LFC_A_LITE_HFGAIN = 16'hFE3A;
	localparam logic [15:0] LFC_B_LITE_HFGAIN = 16'hFE3B;
	localparam logic [15:0] LFC_STATUS_ADDR   = 16'hFEF0;

	// index layout: {set, kind[1:0], channel}
	localparam logic       LFC_CHAN_A    = 1'h0;
	localparam logic       LFC_CHAN_B    = 1'h1;
	localparam logic       LFC_SET_NORM  = 1'h0;
	localparam logic       LFC_SET_LITE  = 1'h1;
	localparam logic [1:0] LFC_KIND_LFG  = 2'h0;
	localparam logic [1:0] LFC_KIND_ZERO = 2'h1;
	localparam logic [1:0] LFC_KIND_POLE = 2'h2;
	localparam logic [1:0] LFC_KIND_HFG  = 2'h3;

	// status register bits
	localparam int LFC_STAT_A_LITE = 0;
	localparam int LFC_STAT_B_LITE = 1;

	// reset and idle values
	localparam logic [7:0] LFC_COEF_RST = 8'h00;
	localparam logic [7:0] LFC_RD_IDLE  = 8'h00;

	// gain scaling of the code, in millidecibel
	localparam int LFC_GAIN_STEP_MDB  = 300;
	localparam int LFC_GAIN_RANGE_MDB = 20000;

	typedef enum logic [1:0]
	{
		LFC_MODE_NORMAL = 2'b01,
		LFC_MODE_LIGHT  = 2'b10
	} lfc_mode_t;

	function automatic logic [LFC_IDX_W-1:0] lfc_idx(input logic setSel, input logic [1:0] kind, input logic chan);
		return {setSel, kind, chan};
	endfunction : lfc_idx

endpackage : lfc_pkg

`default_nettype wire

// [core/lfc_coef_reg.sv]
// one 8-bit read/write coefficient register
// assumes write strobe is already decoded for this register
`default_nettype none

module lfc_coef_reg
(
	input  wire logic                          ref_clk,
	input  wire logic                          arst_n,
	input  wire logic                          wrEn,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] wrData,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] valQ
);
	import lfc_pkg::*;

	logic [LFC_DATA_W-1:0] val_q;
	logic [LFC_DATA_W-1:0] val_d;

	// software value, held until next write
	assign val_d = wrEn ? wrData : val_q;
	assign valQ  = val_q;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			val_q <= LFC_COEF_RST;
		else
			val_q <= val_d; // see R8
	end

endmodule : lfc_coef_reg

`default_nettype wire

// [core/lfc_chan_apply.sv]
// per-channel mode select and update-boundary latch of the applied set
// assumes update is a one-cycle pulse from the filter sample sequencer
`default_nettype none

module lfc_chan_apply
(
	input  wire logic                          ref_clk,
	input  wire logic                          arst_n,
	input  wire logic                          lightLoad,
	input  wire logic                          update,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] normLfGain,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] normZero,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] normPole,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] normHfGain,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] liteLfGain,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] liteZero,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] litePole,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] liteHfGain,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] lfGain,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] zeroSet,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] poleSet,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] hfGain,
	output lfc_pkg::lfc_mode_t                 mode
);
	import lfc_pkg::*;

	lfc_mode_t             mode_q;
	lfc_mode_t             mode_d;
	logic [LFC_DATA_W-1:0] lfg_d, zer_d, pol_d, hfg_d;
	logic [LFC_DATA_W-1:0] lfg_q, zer_q, pol_q, hfg_q;

	// mode only changes at an update, so a sample never sees half a switch
	assign mode_d = update ? (lightLoad ? LFC_MODE_LIGHT : LFC_MODE_NORMAL) : mode_q;

	// pick the whole set for the next mode
	always_comb
	begin
		case (mode_d)
			LFC_MODE_LIGHT:
			begin
				lfg_d = liteLfGain; // see R5
				zer_d = liteZero;
				pol_d = litePole;   // see R7
				hfg_d = liteHfGain; // see R7
			end
			LFC_MODE_NORMAL:
			begin
				lfg_d = normLfGain; // see R1
				zer_d = normZero;   // see R3
				pol_d = normPole;   // see R4
				hfg_d = normHfGain; // see R2
			end
			default:
			begin
				lfg_d = normLfGain;
				zer_d = normZero;
				pol_d = normPole;
				hfg_d = normHfGain;
			end
		endcase
	end

	// all four move together, only on the boundary
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_q <= LFC_MODE_NORMAL;
			lfg_q  <= LFC_COEF_RST;
			zer_q  <= LFC_COEF_RST;
			pol_q  <= LFC_COEF_RST;
			hfg_q  <= LFC_COEF_RST;
		end
		else if (update)
		begin
			mode_q <= mode_d; // see R8
			lfg_q  <= lfg_d;
			zer_q  <= zer_d;
			pol_q  <= pol_d;
			hfg_q  <= hfg_d;
		end
	end

	assign lfGain  = lfg_q;
	assign zeroSet = zer_q;
	assign poleSet = pol_q;
	assign hfGain  = hfg_q;
	assign mode    = mode_q;

endmodule : lfc_chan_apply

`default_nettype wire

// [core/lfc_loop_filter_coefficients.sv]
// top of the loop filter coefficient block: register file, readback and
// per-channel applied coefficient sets for the compensation filter datapath
// assumes a plain register port master and update pulses from the datapath
`default_nettype none

module lfc_loop_filter_coefficients
(
	input  wire logic                          ref_clk,
	input  wire logic                          arst_n,
	// register port
	input  wire logic [lfc_pkg::LFC_ADDR_W-1:0] regAddr,
	input  wire logic [lfc_pkg::LFC_DATA_W-1:0] regWrData,
	input  wire logic                          regWrEn,
	input  wire logic                          regRdEn,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] regRdData,
	// channel A control
	input  wire logic                          lightLoadA,
	input  wire logic                          updateA,
	// channel B control
	input  wire logic                          lightLoadB,
	input  wire logic                          updateB,
	// channel A applied coefficients
	output logic      [lfc_pkg::LFC_DATA_W-1:0] coefLfGainA,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] coefZeroA,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] coefPoleA,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] coefHfGainA,
	output lfc_pkg::lfc_mode_t                 modeA,
	// channel B applied coefficients
	output logic      [lfc_pkg::LFC_DATA_W-1:0] coefLfGainB,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] coefZeroB,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] coefPoleB,
	output logic      [lfc_pkg::LFC_DATA_W-1:0] coefHfGainB,
	output lfc_pkg::lfc_mode_t                 modeB
);
	import lfc_pkg::*;

	logic [LFC_ADDR_W-1:0]   addrOff;
	logic                    addrHit;
	logic                    statHit;
	logic [LFC_IDX_W-1:0]    regIdx;
	logic [LFC_DATA_W-1:0]   coefQ [LFC_NUM_REGS];
	logic [LFC_NUM_REGS-1:0] wrSel;
	logic [LFC_DATA_W-1:0]   statusWord;
	logic [LFC_DATA_W-1:0]   rdMux;
	logic [LFC_DATA_W-1:0]   rdData_q;
	logic [LFC_DATA_W-1:0]   rdData_d;

	// address decode: the coefficient window is sixteen bytes from the base
	assign addrOff = regAddr - LFC_BASE_ADDR;
	assign addrHit = (regAddr >= LFC_BASE_ADDR) && (addrOff < 16'(LFC_NUM_REGS));
	assign regIdx  = addrOff[LFC_IDX_W-1:0];
	assign statHit = (regAddr == LFC_STATUS_ADDR);

	// coefficient storage, one register per byte offset
	genvar gi;
	generate
		for (gi = 0; gi < LFC_NUM_REGS; gi++)
		begin : g_coef
			assign wrSel[gi] = regWrEn && addrHit && (regIdx == LFC_IDX_W'(gi)); // see R8

			lfc_coef_reg u_reg
			(
				.ref_clk (ref_clk),
				.arst_n  (arst_n),
				.wrEn    (wrSel[gi]),
				.wrData  (regWrData),
				.valQ    (coefQ[gi])
			);
		end
	endgenerate

	// channel A applied set; writes only reach the filter at updateA
	lfc_chan_apply u_chanA
	(
		.ref_clk    (ref_clk),
		.arst_n     (arst_n),
		.lightLoad  (lightLoadA),
		.update     (updateA),
		.normLfGain (coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_LFG, LFC_CHAN_A)]),  // see R1
		.normZero   (coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_ZERO, LFC_CHAN_A)]), // see R3
		.normPole   (coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_POLE, LFC_CHAN_A)]), // see R4
		.normHfGain (coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_HFG, LFC_CHAN_A)]),  // see R2
		.liteLfGain (coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_LFG, LFC_CHAN_A)]),  // see R5
		.liteZero   (coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_ZERO, LFC_CHAN_A)]),
		.litePole   (coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_POLE, LFC_CHAN_A)]),
		.liteHfGain (coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_HFG, LFC_CHAN_A)]),  // see R7
		.lfGain     (coefLfGainA),
		.zeroSet    (coefZeroA),
		.poleSet    (coefPoleA),
		.hfGain     (coefHfGainA),
		.mode       (modeA)
	);

	// channel B has its own registers and its own boundary
	lfc_chan_apply u_chanB
	(
		.ref_clk    (ref_clk),
		.arst_n     (arst_n),
		.lightLoad  (lightLoadB),
		.update     (updateB),
		.normLfGain (coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_LFG, LFC_CHAN_B)]),  // see R6
		.normZero   (coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_ZERO, LFC_CHAN_B)]),
		.normPole   (coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_POLE, LFC_CHAN_B)]),
		.normHfGain (coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_HFG, LFC_CHAN_B)]),
		.liteLfGain (coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_LFG, LFC_CHAN_B)]),
		.liteZero   (coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_ZERO, LFC_CHAN_B)]),
		.litePole   (coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_POLE, LFC_CHAN_B)]), // see R7
		.liteHfGain (coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_HFG, LFC_CHAN_B)]),  // see R7
		.lfGain     (coefLfGainB),
		.zeroSet    (coefZeroB),
		.poleSet    (coefPoleB),
		.hfGain     (coefHfGainB),
		.mode       (modeB)
	);

	// status: which set each channel is filtering with right now
	always_comb
	begin
		statusWord                  = LFC_RD_IDLE;
		statusWord[LFC_STAT_A_LITE] = (modeA == LFC_MODE_LIGHT);
		statusWord[LFC_STAT_B_LITE] = (modeB == LFC_MODE_LIGHT);
	end

	// read select; unmapped addresses answer zero
	assign rdMux    = addrHit ? coefQ[regIdx] : (statHit ? statusWord : LFC_RD_IDLE); // see R8
	assign rdData_d = regRdEn ? rdMux : LFC_RD_IDLE;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			rdData_q <= LFC_RD_IDLE;
		else
			rdData_q <= rdData_d;
	end

	assign regRdData = rdData_q;

	// normal low gain of A follows its register at the boundary
	a_lfgain_normal: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R1
		(updateA && !lightLoadA)
		|=> (coefLfGainA == $past(coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_LFG, LFC_CHAN_A)])))
		else $error("channel A normal low gain not applied");

	// normal high gain of B comes from its own code, not the low gain
	a_hfgain_normal: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R2
		(updateB && !lightLoadB)
		|=> (coefHfGainB == $past(coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_HFG, LFC_CHAN_B)]))
		&& (modeB == LFC_MODE_NORMAL))
		else $error("channel B normal high gain not applied");

	// zero placement of A in normal mode
	a_zero_place: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R3
		(updateA && !lightLoadA)
		|=> (coefZeroA == $past(coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_ZERO, LFC_CHAN_A)])))
		else $error("channel A normal zero not applied");

	// pole placement of B in normal mode
	a_pole_place: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R4
		(updateB && !lightLoadB)
		|=> (coefPoleB == $past(coefQ[lfc_idx(LFC_SET_NORM, LFC_KIND_POLE, LFC_CHAN_B)])))
		else $error("channel B normal pole not applied");

	// light load set replaces the normal one for A
	a_light_set: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R5
		(updateA && lightLoadA)
		|=> (modeA == LFC_MODE_LIGHT)
		&& (coefLfGainA == $past(coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_LFG, LFC_CHAN_A)]))
		&& (coefZeroA == $past(coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_ZERO, LFC_CHAN_A)])))
		else $error("channel A light load set not applied");

	// B output holds through A activity while B sees no boundary
	a_chan_indep: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R6
		(!updateB && updateA)
		|=> $stable(coefLfGainB) && $stable(coefZeroB) && $stable(coefPoleB) && $stable(modeB))
		else $error("channel B changed without its own update");

	// light pole and high gain of B
	a_light_extra: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R7
		(updateB && lightLoadB)
		|=> (coefPoleB == $past(coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_POLE, LFC_CHAN_B)]))
		&& (coefHfGainB == $past(coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_HFG, LFC_CHAN_B)])))
		else $error("channel B light pole or high gain not applied");

	// a written coefficient reads back when the same address is read in the next cycle
	a_reg_readback: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R8
		(regWrEn && addrHit) ##1 (regRdEn && (regAddr == $past(regAddr)))
		|=> (regRdData == $past(regWrData, 2)))
		else $error("coefficient readback mismatch");

	// read data only in the cycle after a read strobe
	a_rd_idle: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R8
		!regRdEn |=> (regRdData == LFC_RD_IDLE))
		else $error("read data outside read answer cycle");

	// writes never reach the filter between boundaries
	a_hold_noupd: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R8
		(!updateA ##1 !updateA)
		|=> $stable(coefLfGainA) && $stable(coefHfGainA) && $stable(coefPoleA))
		else $error("channel A coefficients changed off boundary");

	// A output holds through B activity while A sees no boundary
	a_chan_a_indep: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R6
		(!updateA && updateB)
		|=> $stable(coefLfGainA) && $stable(coefZeroA) && $stable(coefHfGainA) && $stable(modeA))
		else $error("channel A changed without its own update");

	// light pole and high gain of A come from the light set
	a_light_a_extra: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R7
		(updateA && lightLoadA)
		|=> (coefPoleA == $past(coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_POLE, LFC_CHAN_A)]))
		&& (coefHfGainA == $past(coefQ[lfc_idx(LFC_SET_LITE, LFC_KIND_HFG, LFC_CHAN_A)])))
		else $error("channel A light pole or high gain not applied");

endmodule : lfc_loop_filter_coefficients

`default_nettype wire

// [bench/lfc_loop_filter_coefficients_tb.sv]
// self-checking bench of the loop filter coefficient block
// assumes lfc_pkg is compiled first; the bench drives every port itself
`default_nettype none

module lfc_loop_filter_coefficients_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lfc_pkg::*;

	logic                  ref_clk     = 1'b0;
	logic                  arst_n      = 1'b0;
	logic [LFC_ADDR_W-1:0] regAddr     = 16'h0000;
	logic [LFC_DATA_W-1:0] regWrData   = 8'h00;
	logic                  regWrEn     = 1'b0;
	logic                  regRdEn     = 1'b0;
	logic [LFC_DATA_W-1:0] regRdData;
	logic                  lightLoadA  = 1'b0;
	logic                  updateA     = 1'b0;
	logic                  lightLoadB  = 1'b0;
	logic                  updateB     = 1'b0;
	logic [LFC_DATA_W-1:0] coefLfGainA;
	logic [LFC_DATA_W-1:0] coefZeroA;
	logic [LFC_DATA_W-1:0] coefPoleA;
	logic [LFC_DATA_W-1:0] coefHfGainA;
	lfc_mode_t             modeA;
	logic [LFC_DATA_W-1:0] coefLfGainB;
	logic [LFC_DATA_W-1:0] coefZeroB;
	logic [LFC_DATA_W-1:0] coefPoleB;
	logic [LFC_DATA_W-1:0] coefHfGainB;
	lfc_mode_t             modeB;
	int                    failCount   = 0;
	int                    cmpCount    = 0;

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	lfc_loop_filter_coefficients DUT
	(
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.regAddr     (regAddr),
		.regWrData   (regWrData),
		.regWrEn     (regWrEn),
		.regRdEn     (regRdEn),
		.regRdData   (regRdData),
		.lightLoadA  (lightLoadA),
		.updateA     (updateA),
		.lightLoadB  (lightLoadB),
		.updateB     (updateB),
		.coefLfGainA (coefLfGainA),
		.coefZeroA   (coefZeroA),
		.coefPoleA   (coefPoleA),
		.coefHfGainA (coefHfGainA),
		.modeA       (modeA),
		.coefLfGainB (coefLfGainB),
		.coefZeroB   (coefZeroB),
		.coefPoleB   (coefPoleB),
		.coefHfGainB (coefHfGainB),
		.modeB       (modeB)
	);

	// test pattern per register index; salt 0 and F give 0x0F/0xF0 and 0xFF/0x00 at the ends
	function automatic logic [7:0] pat(input logic [3:0] i, input logic [3:0] g);
		return {i ^ g, ~i};
	endfunction : pat

	task automatic results();
		if (failCount == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			failCount++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one-cycle write strobe; an idle edge before each access keeps drivers single per step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
	endtask : wr

	// read data looked at in the cycle after the strobe, and must be gone one cycle later
	task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1;
		chk("read data", regRdData, exp);
		@(posedge ref_clk);
		#1;
		chk("read idle", regRdData, LFC_RD_IDLE);
	endtask : rdChk

	task automatic upd(input logic la, input logic lb, input logic ua, input logic ub);
		@(posedge ref_clk);
		lightLoadA <= la;
		lightLoadB <= lb;
		updateA <= ua;
		updateB <= ub;
		@(posedge ref_clk);
		updateA <= 1'b0;
		updateB <= 1'b0;
		#1;
	endtask : upd

	// applied set of one channel against the pattern written with salt g, or the reset value when clr
	task automatic chkSet(input logic ch, input logic st, input logic [3:0] g, input logic clr = 1'b0);
		logic [7:0] got [4];
		got[0] = ch ? coefLfGainB : coefLfGainA;
		got[1] = ch ? coefZeroB : coefZeroA;
		got[2] = ch ? coefPoleB : coefPoleA;
		got[3] = ch ? coefHfGainB : coefHfGainA;
		for (int k = 0; k < 4; k++)
			chk("applied coefficient", got[k], clr ? LFC_COEF_RST : pat({st, k[1:0], ch}, g));
		chk("mode", {6'h00, ch ? modeB : modeA}, {6'h00, st ? LFC_MODE_LIGHT : LFC_MODE_NORMAL});
	endtask : chkSet

	// watchdog: a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		failCount++;
		results();
	end

	// main sequence
	initial
	begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		#1;
		chk("reset outputs", coefLfGainA | coefZeroA | coefPoleA | coefHfGainA | coefLfGainB | coefZeroB
			| coefPoleB | coefHfGainB, LFC_COEF_RST);
		chkSet(1'b0, 1'b0, 4'h0, 1'b1);
		chkSet(1'b1, 1'b0, 4'h0, 1'b1);
		for (int i = 0; i < LFC_NUM_REGS; i++)
			rdChk(LFC_BASE_ADDR + 16'(i), LFC_COEF_RST);
		for (int i = 0; i < LFC_NUM_REGS; i++)
			wr(LFC_BASE_ADDR + 16'(i), pat(4'(i), 4'h0));
		for (int i = 0; i < LFC_NUM_REGS; i++)
			rdChk(LFC_BASE_ADDR + 16'(i), pat(4'(i), 4'h0));
		// mode inputs move without an update boundary: nothing applied yet
		upd(1'b1, 1'b1, 1'b0, 1'b0);
		chk("held outputs", coefLfGainA | coefHfGainB | coefZeroB | coefPoleA, 8'h00);
		chk("held mode", {6'h00, modeA}, {6'h00, LFC_MODE_NORMAL});
		upd(1'b0, 1'b1, 1'b1, 1'b1);
		chkSet(1'b0, 1'b0, 4'h0);
		chkSet(1'b1, 1'b1, 4'h0);
		rdChk(LFC_STATUS_ADDR, 8'h02);
		wr(LFC_STATUS_ADDR, 8'hFF);
		rdChk(LFC_STATUS_ADDR, 8'h02);
		wr(16'h0000, 8'hAA);
		rdChk(16'h0000, LFC_RD_IDLE);
		rdChk(16'hFE3C, LFC_RD_IDLE);
		rdChk(LFC_A_NORM_LFGAIN, pat(4'h0, 4'h0));
		// new values stay off the outputs until the next boundary
		for (int i = 0; i < LFC_NUM_REGS; i++)
			wr(LFC_BASE_ADDR + 16'(i), pat(4'(i), 4'hF));
		chkSet(1'b0, 1'b0, 4'h0);
		chkSet(1'b1, 1'b1, 4'h0);
		upd(1'b1, 1'b0, 1'b1, 1'b1);
		chkSet(1'b0, 1'b1, 4'hF);
		chkSet(1'b1, 1'b0, 4'hF);
		rdChk(LFC_STATUS_ADDR, 8'h01);
		upd(1'b0, 1'b1, 1'b0, 1'b1);
		chkSet(1'b0, 1'b1, 4'hF);
		chkSet(1'b1, 1'b1, 4'hF);
		// write and boundary in the same cycle: the old value is applied
		@(posedge ref_clk);
		regAddr <= LFC_A_NORM_LFGAIN;
		regWrData <= 8'h3C;
		regWrEn <= 1'b1;
		lightLoadA <= 1'b0;
		updateA <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		updateA <= 1'b0;
		#1;
		chk("old gain applied", coefLfGainA, pat(4'h0, 4'hF));
		upd(1'b0, 1'b1, 1'b1, 1'b0);
		chk("new gain applied", coefLfGainA, 8'h3C);
		chk("mode after return", {6'h00, modeA}, {6'h00, LFC_MODE_NORMAL});
		// write then read with no gap: the read must see the new byte
		@(posedge ref_clk);
		regAddr <= LFC_A_LITE_POLE;
		regWrData <= 8'h5A;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1;
		chk("read after write", regRdData, 8'h5A);
		// reset in mid-run clears the registers and both applied sets
		@(posedge ref_clk);
		arst_n <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("reset read data", regRdData, LFC_RD_IDLE);
		chkSet(1'b0, 1'b0, 4'h0, 1'b1);
		chkSet(1'b1, 1'b0, 4'h0, 1'b1);
		@(posedge ref_clk);
		arst_n <= 1'b1;
		rdChk(LFC_A_LITE_POLE, LFC_COEF_RST);
		upd(1'b1, 1'b1, 1'b1, 1'b1);
		chkSet(1'b0, 1'b1, 4'h0, 1'b1);
		chkSet(1'b1, 1'b1, 4'h0, 1'b1);
		results();
	end

endmodule : lfc_loop_filter_coefficients_tb

`default_nettype wire
